// ===== cafc_cfg.svh
// cafc_cfg.svh: offsets, field positions and reset values of the filter control block
// assumes: included by its bare name by the package and the design module
`ifndef CAFC_CFG_SVH
`define CAFC_CFG_SVH

// ----------------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------------
`define CAFC_ADDR_W          8
`define CAFC_OFS_CTRL_WORD_3 8'h00
`define CAFC_OFS_CTRL_WORD_4 8'h04
`define CAFC_OFS_CTRL_WORD_5 8'h08
`define CAFC_OFS_STATUS      8'h0C

// ----------------------------------------------------------------------------
// geometry and field layout within one filter byte
// ----------------------------------------------------------------------------
`define CAFC_NUM_FILTERS     12
`define CAFC_FIRST_FILTER    12
`define CAFC_NUM_WORDS       3
`define CAFC_SLOTS_PER_WORD  4
`define CAFC_SLOT_W          8
`define CAFC_EN_BIT          7
`define CAFC_MASK_HI         6
`define CAFC_MASK_LO         5
`define CAFC_DEST_HI         4
`define CAFC_DEST_LO         0
`define CAFC_NUM_MASKS       4

// ----------------------------------------------------------------------------
// status word layout and reset values
// ----------------------------------------------------------------------------
`define CAFC_STAT_BLOCK_LO   0
`define CAFC_STAT_COUNT_LO   16
`define CAFC_SLOT_RESET      8'h00
`define CAFC_WORD_RESET      32'h00000000

`endif

// ===== cafc_pkg.sv
// cafc_pkg.sv: types shared by the filter control block
// assumes: cafc_cfg.svh is on the include path
`include "cafc_cfg.svh"

package cafc_pkg;

  typedef logic [`CAFC_SLOT_W-1:0]        cafc_slot_t;
  typedef logic [1:0]                     cafc_mask_t;
  typedef logic [4:0]                     cafc_dest_t;
  typedef logic [`CAFC_NUM_MASKS-1:0]     cafc_onehot_t;
  typedef logic [`CAFC_ADDR_W-1:0]        cafc_addr_t;
  typedef logic [31:0]                    cafc_word_t;

endpackage

// ===== cafc_filter_ctrl.sv
// cafc_filter_ctrl.sv: control fields of acceptance filters 12 to 23 behind a plain register port
// assumes: one 100 MHz clock, synchronous active-high reset, a master that never overlaps strobes
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "cafc_cfg.svh"

// Operation
// R1 - one enable bit activates each filter
// R2 - two-bit field picks acceptance mask 0-3
// R3 - five-bit field picks receive buffer 0-31
// R4 - fields change only while filter is disabled
// R5 - all bits read/write, reset to zero
// R6 - byte: enable top, mask next, destination low
// R7 - four filters per word, lowest in low byte
// R8 - filters 12 and 13 fill word's low half
// R9 - write to enabled filter keeps mask, destination
module cafc_filter_ctrl
  import cafc_pkg::*;
(
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 reset_i,
  input  wire logic                                 clk_en_i,
  input  wire cafc_addr_t                           reg_addr_i,
  input  wire cafc_word_t                           reg_wdata_i,
  input  wire logic                                 reg_wr_i,
  input  wire logic                                 reg_rd_i,
  output logic [31:0]                               reg_rdata_o,
  output logic [`CAFC_NUM_FILTERS-1:0]              filter_active_bit_o,
  output logic [2*`CAFC_NUM_FILTERS-1:0]            mask_choice_o,
  output logic [`CAFC_NUM_MASKS*`CAFC_NUM_FILTERS-1:0] mask_onehot_o,
  output logic [5*`CAFC_NUM_FILTERS-1:0]            destination_buffer_choice_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  cafc_slot_t                       slot_r      [`CAFC_NUM_FILTERS];
  cafc_slot_t                       slot_nxt    [`CAFC_NUM_FILTERS];
  logic [`CAFC_NUM_FILTERS-1:0]     blocked_r;
  logic [`CAFC_NUM_FILTERS-1:0]     blocked_nxt;
  logic [31:0]                      rdata_r;
  logic [31:0]                      rdata_nxt;
  cafc_onehot_t                     onehot_r    [`CAFC_NUM_FILTERS];
  cafc_onehot_t                     onehot_nxt  [`CAFC_NUM_FILTERS];

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  wire logic                        hit_w3;
  wire logic                        hit_w4;
  wire logic                        hit_w5;
  wire logic                        hit_stat;
  wire logic [`CAFC_NUM_WORDS-1:0]  word_wr;
  wire logic                        stat_wr;

  assign hit_w3   = (reg_addr_i == `CAFC_OFS_CTRL_WORD_3);
  assign hit_w4   = (reg_addr_i == `CAFC_OFS_CTRL_WORD_4);
  assign hit_w5   = (reg_addr_i == `CAFC_OFS_CTRL_WORD_5);
  assign hit_stat = (reg_addr_i == `CAFC_OFS_STATUS);
  assign word_wr  = {hit_w5, hit_w4, hit_w3} & {`CAFC_NUM_WORDS{reg_wr_i}};
  assign stat_wr  = hit_stat & reg_wr_i;

  // --------------------------------------------------------------------------
  // per-filter update
  // --------------------------------------------------------------------------
  wire logic [`CAFC_NUM_FILTERS-1:0] slot_wr;
  wire logic [`CAFC_NUM_FILTERS-1:0] fields_locked;
  wire logic [`CAFC_NUM_FILTERS-1:0] refused;
  wire logic [`CAFC_NUM_FILTERS-1:0] blk_clear;
  wire cafc_slot_t                   wr_byte     [`CAFC_NUM_FILTERS];

  genvar gi;
  generate
    for (gi = 0; gi < `CAFC_NUM_FILTERS; gi++) begin : g_slot
      // filter gi sits in word gi/4, byte lane gi%4; lowest filter in bits 7:0
      assign wr_byte[gi] = reg_wdata_i[(gi % `CAFC_SLOTS_PER_WORD)*`CAFC_SLOT_W +: `CAFC_SLOT_W]; // [R7] [R8]
      assign slot_wr[gi] = word_wr[gi / `CAFC_SLOTS_PER_WORD]; // [R7]

      // an enabled filter locks its selectors; the enable stays writable so it can be cleared
      assign fields_locked[gi] = slot_r[gi][`CAFC_EN_BIT]; // [R4]

      // a write that tries to change a locked selector is refused and recorded
      assign refused[gi] = slot_wr[gi] & fields_locked[gi] &
                           (wr_byte[gi][`CAFC_MASK_HI:`CAFC_DEST_LO] !=
                            slot_r[gi][`CAFC_MASK_HI:`CAFC_DEST_LO]); // [R9]

      always_comb begin
        slot_nxt[gi] = slot_r[gi];
        if (slot_wr[gi]) begin
          slot_nxt[gi][`CAFC_EN_BIT] = wr_byte[gi][`CAFC_EN_BIT]; // [R1] [R6]
          if (!fields_locked[gi]) begin
            slot_nxt[gi][`CAFC_MASK_HI:`CAFC_MASK_LO] = wr_byte[gi][`CAFC_MASK_HI:`CAFC_MASK_LO]; // [R2] [R4] [R6]
            slot_nxt[gi][`CAFC_DEST_HI:`CAFC_DEST_LO] = wr_byte[gi][`CAFC_DEST_HI:`CAFC_DEST_LO]; // [R3] [R4] [R6]
          end
        end
      end

      // mask one-hot: only the chosen mask of an active filter is flagged
      always_comb begin
        onehot_nxt[gi] = '0;
        if (slot_nxt[gi][`CAFC_EN_BIT]) begin
          case (slot_nxt[gi][`CAFC_MASK_HI:`CAFC_MASK_LO])
            2'h0:    onehot_nxt[gi] = 4'h1; // [R2]
            2'h1:    onehot_nxt[gi] = 4'h2; // [R2]
            2'h2:    onehot_nxt[gi] = 4'h4; // [R2]
            2'h3:    onehot_nxt[gi] = 4'h8; // [R2]
            default: onehot_nxt[gi] = '0;
          endcase
        end
      end

      // sticky refusal flag: a new refusal wins over a clear in the same cycle
      assign blk_clear[gi]   = stat_wr & reg_wdata_i[`CAFC_STAT_BLOCK_LO + gi];
      assign blocked_nxt[gi] = refused[gi] | (blocked_r[gi] & ~blk_clear[gi]);

      assign filter_active_bit_o[gi]               = slot_r[gi][`CAFC_EN_BIT]; // [R1]
      assign mask_choice_o[2*gi +: 2]              = slot_r[gi][`CAFC_MASK_HI:`CAFC_MASK_LO]; // [R2]
      assign destination_buffer_choice_o[5*gi +: 5] = slot_r[gi][`CAFC_DEST_HI:`CAFC_DEST_LO]; // [R3]
      assign mask_onehot_o[`CAFC_NUM_MASKS*gi +: `CAFC_NUM_MASKS] = onehot_r[gi];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // read-back words
  // --------------------------------------------------------------------------
  wire cafc_word_t  word3_val;
  wire cafc_word_t  word4_val;
  wire cafc_word_t  word5_val;
  wire cafc_word_t  stat_val;
  logic [3:0]       active_count;

  assign word3_val = {slot_r[3], slot_r[2], slot_r[1], slot_r[0]};   // [R7] [R8]
  assign word4_val = {slot_r[7], slot_r[6], slot_r[5], slot_r[4]};   // [R7]
  assign word5_val = {slot_r[11], slot_r[10], slot_r[9], slot_r[8]}; // [R7]

  always_comb begin
    active_count = 4'h0;
    for (int k = 0; k < `CAFC_NUM_FILTERS; k++) begin
      active_count = active_count + {3'h0, slot_r[k][`CAFC_EN_BIT]};
    end
  end

  assign stat_val = {12'h000, active_count, 4'h0, blocked_r};

  // unmapped addresses read as zero
  assign rdata_nxt = !reg_rd_i ? 32'h00000000 :
                     hit_w3    ? word3_val :
                     hit_w4    ? word4_val :
                     hit_w5    ? word5_val :
                     hit_stat  ? stat_val  : 32'h00000000; // [R5]

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int k = 0; k < `CAFC_NUM_FILTERS; k++) begin
        slot_r[k]   <= `CAFC_SLOT_RESET; // [R5]
        onehot_r[k] <= '0;
      end
    end else if (clk_en_i) begin
      for (int k = 0; k < `CAFC_NUM_FILTERS; k++) begin
        slot_r[k]   <= slot_nxt[k];
        onehot_r[k] <= onehot_nxt[k];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      blocked_r <= '0;
      rdata_r   <= `CAFC_WORD_RESET;
    end else if (clk_en_i) begin
      blocked_r <= blocked_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule

// ===== cafc_filter_ctrl_chk.sv
// cafc_filter_ctrl_chk.sv: assertions on the ports of the filter control block
// assumes: bound to cafc_filter_ctrl, one clock, reset_i synchronous active high
`timescale 1ns/1ps
module cafc_filter_ctrl_chk
  import cafc_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire logic        clk_en_i,
  input wire cafc_addr_t  reg_addr_i,
  input wire cafc_word_t  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [11:0] filter_active_bit_o,
  input wire logic [23:0] mask_choice_o,
  input wire logic [47:0] mask_onehot_o,
  input wire logic [59:0] destination_buffer_choice_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire wr0 = reg_wr_i && clk_en_i && reg_addr_i == 8'h00;
  wire wr8 = reg_wr_i && clk_en_i && reg_addr_i == 8'h08;
  a_wr_enable: assert property (wr0 |=> filter_active_bit_o[0] == $past(reg_wdata_i[7]))
    else $error("enable bit not written");
  a_lock_hold: assert property (wr0 && filter_active_bit_o[0] |=>
    $stable(mask_choice_o[1:0]) && $stable(destination_buffer_choice_o[4:0])) else $error("locked fields changed");
  a_unlock_mask: assert property (wr0 && !filter_active_bit_o[0] |=> mask_choice_o[1:0] == $past(reg_wdata_i[6:5]))
    else $error("mask field not written");
  a_unlock_dest: assert property (wr0 && !filter_active_bit_o[1] |=>
    destination_buffer_choice_o[9:5] == $past(reg_wdata_i[12:8])) else $error("destination field not written");
  a_top_slot: assert property (wr8 && !filter_active_bit_o[11] |=>
    {mask_choice_o[23:22], destination_buffer_choice_o[59:55]} == $past(reg_wdata_i[30:24])) else $error("top byte wrong");
  a_onehot_map: assert property (mask_onehot_o[3:0] == (filter_active_bit_o[0] ? 4'h1 << mask_choice_o[1:0] : 4'h0))
    else $error("one-hot mask wrong");
  a_read_back: assert property (reg_rd_i && clk_en_i && reg_addr_i == 8'h00 |=> reg_rdata_o[7:0] ==
    {filter_active_bit_o[0], mask_choice_o[1:0], destination_buffer_choice_o[4:0]}) else $error("read back wrong");
  a_gated_hold: assert property (!clk_en_i |=> $stable(filter_active_bit_o) && $stable(mask_choice_o))
    else $error("state moved while gated");
  c_locked_wr: cover property (wr0 && filter_active_bit_o[0]);
  c_read: cover property (reg_rd_i && clk_en_i);
  c_gated_wr: cover property (!clk_en_i && reg_wr_i);
endmodule
bind cafc_filter_ctrl cafc_filter_ctrl_chk cafc_filter_ctrl_chk_inst (.*);

// ===== tb.sv
// tb.sv: self-checking bench of the filter control block
// assumes: cafc_pkg and the checker are compiled first
`timescale 1ns/1ps
module tb;
  import cafc_pkg::*;
  logic        sys_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  cafc_addr_t  reg_addr_i = 8'h00;
  cafc_word_t  reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic [11:0] filter_active_bit_o;
  logic [23:0] mask_choice_o;
  logic [47:0] mask_onehot_o;
  logic [59:0] destination_buffer_choice_o;
  int          bad_count = 0, cmp_count = 0;
  cafc_addr_t  row_a[4] = '{8'h00, 8'h04, 8'h08, 8'h10};
  cafc_word_t  row_d[4] = '{32'h7F5F3F1F, 32'h60402000, 32'h7F00601F, 32'hFFFFFFFF};
  cafc_word_t  row_e[4] = '{32'h7F5F3F1F, 32'h60402000, 32'h7F00601F, 32'h00000000};
  cafc_filter_ctrl cafc_filter_ctrl_inst (.*);
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task chk(input string n, input cafc_word_t e, input cafc_word_t s);
    cmp_count++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  task wr(input cafc_addr_t a, input cafc_word_t d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task rd(input cafc_addr_t a, input cafc_word_t e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("read data", e, reg_rdata_o);
    @(posedge sys_clk_i);
    #1;
    chk("idle read data", 32'h0, reg_rdata_o);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 3; i++) rd(row_a[i], 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(row_a[i], row_d[i]);
      rd(row_a[i], row_e[i]);
    end
    chk("dest 23", 32'h1F, 32'(destination_buffer_choice_o[59:55]));
    chk("mask 13", 32'h1, 32'(mask_choice_o[3:2]));
    $display("test table done");
    wr(8'h00, 32'h000000A3);
    chk("onehot 12", 32'h2, 32'(mask_onehot_o[3:0]));
    chk("enables", 32'h1, 32'(filter_active_bit_o));
    wr(8'h00, 32'h000000FF);
    rd(8'h00, 32'h000000A3);
    wr(8'h00, 32'h0000007F);
    rd(8'h00, 32'h00000023);
    wr(8'h00, 32'h0000007F);
    rd(8'h00, 32'h0000007F);
    rd(8'h0C, 32'h00000001);
    wr(8'h0C, 32'h00000001);
    rd(8'h0C, 32'h00000000);
    wr(8'h00, 32'h00000080);
    rd(8'h0C, 32'h00010000);
    wr(8'h00, 32'h00000000);
    rd(8'h0C, 32'h00000000);
    $display("test lock done");
    @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    wr(8'h04, 32'hFFFFFFFF);
    @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    rd(8'h04, 32'h60402000);
    $display("test gate done");
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    #1;
    chk("enables after reset", 32'h0, 32'(filter_active_bit_o));
    chk("masks after reset", 32'h0, 32'(mask_choice_o));
    chk("dests low after reset", 32'h0, destination_buffer_choice_o[31:0]);
    chk("dests high after reset", 32'h0, 32'(destination_buffer_choice_o[59:32]));
    rd(8'h08, 32'h0);
    $display("test mid reset done");
    test_done;
  end
endmodule
